// ---- rtl/aerunc_regs.svh ----
// Register offsets, field positions and reset values of the error reporting registers
`ifndef AERUNC_REGS_SVH
`define AERUNC_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define AERUNC_OFS_CAP_ID        12'h100
`define AERUNC_OFS_NEXT_VER      12'h102
`define AERUNC_OFS_FLAGS         12'h104
`define AERUNC_OFS_MASK          12'h108

// ****************************************
// Fixed values and reset values
// ****************************************
`define AERUNC_CAP_ID_VAL        16'h0001
`define AERUNC_NEXT_PTR_VAL      12'h000
`define AERUNC_VERSION_VAL       4'h1
`define AERUNC_FLAGS_RST         32'h00000000
`define AERUNC_MASK_RST          32'h00000000

// ****************************************
// Field positions
// ****************************************
`define AERUNC_BIT_UR            20
`define AERUNC_BIT_ECRC          19
`define AERUNC_BIT_MAL           18
`define AERUNC_BIT_OVF           17
`define AERUNC_BIT_UNXP          16
`define AERUNC_BIT_CABT          15
`define AERUNC_BIT_CTO           14
`define AERUNC_BIT_FC            13
`define AERUNC_BIT_PSN           12
`define AERUNC_BIT_DLL           4
`define AERUNC_IMPL_MASK         32'h001FF010

`endif

// ---- rtl/aerunc_pkg.sv ----
// Types shared by the error reporting register files
package aerunc_pkg;

  // Error detection events, one pulse per error kind
  typedef struct packed {
    logic unsupported_request;
    logic end_to_end_crc;
    logic malformed_packet;
    logic receiver_overflow;
    logic unexpected_completion;
    logic completer_abort;
    logic completion_timeout;
    logic flow_credit_protocol;
    logic poisoned_packet;
    logic link_protocol;
  } aerunc_events_t;

  // Configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } aerunc_cfg_req_t;

  // Configuration access answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } aerunc_cfg_rsp_t;

  // Reported error, after masking
  typedef struct packed {
    logic        valid;
    logic [31:0] bits;
  } aerunc_report_t;

endpackage

// ---- rtl/aerunc_event_map.sv ----
// Maps error events onto their flag positions
`timescale 1ns/1ns
`include "aerunc_regs.svh"

module aerunc_event_map (
  // Events
  input  aerunc_pkg::aerunc_events_t ev_in,
  // Flag-aligned vector
  output logic [31:0]                vec_out
);
  import aerunc_pkg::*;

  always_comb begin
    vec_out                      = 32'h00000000;
    vec_out[`AERUNC_BIT_UR]      = ev_in.unsupported_request;
    vec_out[`AERUNC_BIT_ECRC]    = ev_in.end_to_end_crc;
    vec_out[`AERUNC_BIT_MAL]     = ev_in.malformed_packet;
    vec_out[`AERUNC_BIT_OVF]     = ev_in.receiver_overflow;
    vec_out[`AERUNC_BIT_UNXP]    = ev_in.unexpected_completion;
    vec_out[`AERUNC_BIT_CABT]    = ev_in.completer_abort;
    vec_out[`AERUNC_BIT_CTO]     = ev_in.completion_timeout;
    vec_out[`AERUNC_BIT_FC]      = ev_in.flow_credit_protocol;
    vec_out[`AERUNC_BIT_PSN]     = ev_in.poisoned_packet;
    vec_out[`AERUNC_BIT_DLL]     = ev_in.link_protocol;
  end

endmodule

// ---- rtl/aerunc_reset_gen.sv ----
// Fundamental reset from the synchronous, link and global reset inputs
`timescale 1ns/1ns

module aerunc_reset_gen (
  // Clock and resets
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic link_reset_input_n_in,
  input  wire logic global_reset_input_n_in,
  // Fundamental reset
  output logic      fundamental_reset_out
);

  typedef struct packed {
    logic fundamental_reset;
  } aerunc_rst_state_t;

  aerunc_rst_state_t st;
  aerunc_rst_state_t next_st;

  always_comb begin
    next_st.fundamental_reset = srst_in | ~link_reset_input_n_in | ~global_reset_input_n_in;
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign fundamental_reset_out = st.fundamental_reset;

endmodule

// ---- rtl/aerunc_regs_top.sv ----
// Uncorrectable error status and mask registers with capability header
// Notes on behaviour
// - Offset 100h always reads capability identifier 0001h.
// - Offset 102h upper twelve bits read 000h: last capability.
// - Offset 102h lowest four bits read version 1h.
// - Flags are sticky; written ones clear them, written zeros do nothing.
// - Unsupported request received sets flag bit 20.
// - End-to-end CRC failure sets flag bit 19.
// - Malformed packet sets flag bit 18.
// - Credit overrun by link partner sets flag bit 17.
// - Completion matching no request sets flag bit 16.
// - Completer abort returned by bridge sets flag bit 15.
// - Completion timeout sets flag bit 14.
// - Flow control protocol violation sets flag bit 13.
// - Poisoned packet received sets flag bit 12.
// - Data link protocol violation sets flag bit 4.
// - Bits 31:21, 11:5, 3:0 of flags and mask read zero.
// - Masked error: no flag, no message, no header log, no pointer.
// - Mask bits read/write, aligned with flags, reset to zero.
// - Each primary interface error has its own flag, set on occurrence.
// - Registers cleared only by fundamental reset from srst_in or either reset input.
// - Registers sit in extended configuration space from 100h.
`timescale 1ns/1ns
`include "aerunc_regs.svh"

module aerunc_regs_top (
  // Clock and resets
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  input  wire logic                    link_reset_input_n_in,
  input  wire logic                    global_reset_input_n_in,
  // Configuration access
  input  aerunc_pkg::aerunc_cfg_req_t  cfg_req_in,
  output aerunc_pkg::aerunc_cfg_rsp_t  cfg_rsp_out,
  // Error events
  input  aerunc_pkg::aerunc_events_t   events_in,
  // Reporting
  output aerunc_pkg::aerunc_report_t   report_out,
  output logic [31:0]                  flags_out
);
  import aerunc_pkg::*;

  typedef struct packed {
    logic [31:0]     flags;
    logic [31:0]     mask;
    aerunc_cfg_rsp_t rsp;
    aerunc_report_t  rpt;
  } aerunc_state_t;

  aerunc_state_t st;
  aerunc_state_t next_st;
  logic          fundamental_reset;
  logic [31:0]   ev_vec;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] be_expand(input logic [3:0] be);
    be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a, input logic [31:0] f, input logic [31:0] m);
    unique case (a)
      // capability id plus pointer and version
      `AERUNC_OFS_CAP_ID: read_word = {`AERUNC_NEXT_PTR_VAL, `AERUNC_VERSION_VAL, `AERUNC_CAP_ID_VAL};
      `AERUNC_OFS_FLAGS:  read_word = f & `AERUNC_IMPL_MASK;
      `AERUNC_OFS_MASK:   read_word = m & `AERUNC_IMPL_MASK;
      default:            read_word = 32'h00000000;
    endcase
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  aerunc_reset_gen u_rst (
    .clk_in                  (clk_in),
    .srst_in                 (srst_in),
    .link_reset_input_n_in   (link_reset_input_n_in),
    .global_reset_input_n_in (global_reset_input_n_in),
    .fundamental_reset_out   (fundamental_reset)
  );

  aerunc_event_map u_map (
    .ev_in   (events_in),
    .vec_out (ev_vec)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic [31:0] wr_bits;
  logic [31:0] hit;
  logic        wr_flags;
  logic        wr_mask;

  always_comb begin
    next_st  = st;
    wr_flags = cfg_req_in.wr && (cfg_req_in.addr == `AERUNC_OFS_FLAGS);
    wr_mask  = cfg_req_in.wr && (cfg_req_in.addr == `AERUNC_OFS_MASK);
    wr_bits  = cfg_req_in.wdata & be_expand(cfg_req_in.be) & `AERUNC_IMPL_MASK;
    hit      = ev_vec & ~st.mask & `AERUNC_IMPL_MASK;
    if (wr_flags) begin
      next_st.flags = st.flags & ~wr_bits;
    end
    next_st.flags = (next_st.flags | hit) & `AERUNC_IMPL_MASK;
    if (wr_mask) begin
      next_st.mask = ((st.mask & ~be_expand(cfg_req_in.be)) | wr_bits) & `AERUNC_IMPL_MASK;
    end
    next_st.rsp.ack   = cfg_req_in.rd | cfg_req_in.wr;
    next_st.rsp.rdata = cfg_req_in.rd ? read_word(cfg_req_in.addr, st.flags, st.mask) : 32'h00000000;
    next_st.rpt.valid = |hit;
    next_st.rpt.bits  = hit;
  end

  // ****************************************
  // Registers
  // ****************************************
  // only fundamental reset clears
  always_ff @(posedge clk_in) begin
    if (fundamental_reset) begin
      st.flags <= `AERUNC_FLAGS_RST;
      st.mask  <= `AERUNC_MASK_RST;
      st.rsp   <= '0;
      st.rpt   <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rsp_out = st.rsp;
  assign report_out  = st.rpt;
  assign flags_out   = st.flags;

  // ****************************************
  // Checks
  // ****************************************
  a_cap_id_read: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd && cfg_req_in.addr == 12'h100 |=> cfg_rsp_out.rdata[15:0] == 16'h0001)
    else $error("capability id wrong");

  a_next_ptr_zero: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd && cfg_req_in.addr == 12'h100 |=> cfg_rsp_out.rdata[31:20] == 12'h000)
    else $error("next pointer not zero");

  a_version_one: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd && cfg_req_in.addr == 12'h100 |=> cfg_rsp_out.rdata[19:16] == 4'h1)
    else $error("version wrong");

  a_flag_sticky: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    !(cfg_req_in.wr && cfg_req_in.addr == 12'h104) |=> (flags_out & $past(flags_out)) == $past(flags_out))
    else $error("flag dropped without clear");

  a_ur_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unsupported_request && !st.mask[20] |=> flags_out[20])
    else $error("unsupported request flag not set");

  a_crc_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.end_to_end_crc && !st.mask[19] |=> flags_out[19])
    else $error("crc flag not set");

  a_dll_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.link_protocol && !st.mask[4] |=> flags_out[4])
    else $error("link protocol flag not set");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    ((flags_out | st.mask) & 32'hFFE00FEF) == 32'h00000000)
    else $error("reserved bit set");

  a_mask_blocks: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    st.mask[18] && !flags_out[18] && !(cfg_req_in.wr && cfg_req_in.addr == 12'h108) |=> !flags_out[18] && !report_out.bits[18])
    else $error("masked error reported");

  a_set_wins: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.wr && cfg_req_in.addr == 12'h104 && events_in.poisoned_packet && !st.mask[12] |=> flags_out[12])
    else $error("event lost during clear");

  a_reset_clears: assert property (@(posedge clk_in)
    !link_reset_input_n_in ##1 1'b1 |=> flags_out == 32'h00000000 && st.mask == 32'h00000000)
    else $error("reset did not clear");

  a_mal_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.malformed_packet && !st.mask[18]
    |=> flags_out[18])
    else $error("malformed packet flag not set");

  a_ovf_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.receiver_overflow && !st.mask[17]
    |=> flags_out[17])
    else $error("credit overrun flag not set");

  a_unxp_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unexpected_completion && !st.mask[16]
    |=> flags_out[16])
    else $error("unexpected completion flag not set");

  a_cabt_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completer_abort && !st.mask[15]
    |=> flags_out[15])
    else $error("completer abort flag not set");

  a_cto_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completion_timeout && !st.mask[14]
    |=> flags_out[14])
    else $error("completion timeout flag not set");

  a_fc_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.flow_credit_protocol && !st.mask[13]
    |=> flags_out[13])
    else $error("flow credit flag not set");

  a_psn_sets: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.poisoned_packet && !st.mask[12]
    |=> flags_out[12])
    else $error("poisoned packet flag not set");

  a_ur_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unsupported_request && !st.mask[20]
    |=> report_out.valid && report_out.bits[20])
    else $error("unsupported request not reported");

  a_crc_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.end_to_end_crc && !st.mask[19]
    |=> report_out.valid && report_out.bits[19])
    else $error("crc error not reported");

  a_mal_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.malformed_packet && !st.mask[18]
    |=> report_out.valid && report_out.bits[18])
    else $error("malformed packet not reported");

  a_ovf_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.receiver_overflow && !st.mask[17]
    |=> report_out.valid && report_out.bits[17])
    else $error("credit overrun not reported");

  a_unxp_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unexpected_completion && !st.mask[16]
    |=> report_out.valid && report_out.bits[16])
    else $error("unexpected completion not reported");

  a_cabt_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completer_abort && !st.mask[15]
    |=> report_out.valid && report_out.bits[15])
    else $error("completer abort not reported");

  a_cto_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completion_timeout && !st.mask[14]
    |=> report_out.valid && report_out.bits[14])
    else $error("completion timeout not reported");

  a_fc_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.flow_credit_protocol && !st.mask[13]
    |=> report_out.valid && report_out.bits[13])
    else $error("flow credit error not reported");

  a_psn_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.poisoned_packet && !st.mask[12]
    |=> report_out.valid && report_out.bits[12])
    else $error("poisoned packet not reported");

  a_dll_report: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.link_protocol && !st.mask[4]
    |=> report_out.valid && report_out.bits[4])
    else $error("link protocol error not reported");

  a_ur_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unsupported_request && st.mask[20] && !flags_out[20]
    |=> !flags_out[20] && !report_out.bits[20])
    else $error("masked unsupported request seen");

  a_crc_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.end_to_end_crc && st.mask[19] && !flags_out[19]
    |=> !flags_out[19] && !report_out.bits[19])
    else $error("masked crc error seen");

  a_ovf_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.receiver_overflow && st.mask[17] && !flags_out[17]
    |=> !flags_out[17] && !report_out.bits[17])
    else $error("masked credit overrun seen");

  a_unxp_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.unexpected_completion && st.mask[16] && !flags_out[16]
    |=> !flags_out[16] && !report_out.bits[16])
    else $error("masked unexpected completion seen");

  a_cabt_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completer_abort && st.mask[15] && !flags_out[15]
    |=> !flags_out[15] && !report_out.bits[15])
    else $error("masked completer abort seen");

  a_cto_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.completion_timeout && st.mask[14] && !flags_out[14]
    |=> !flags_out[14] && !report_out.bits[14])
    else $error("masked completion timeout seen");

  a_fc_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.flow_credit_protocol && st.mask[13] && !flags_out[13]
    |=> !flags_out[13] && !report_out.bits[13])
    else $error("masked flow credit error seen");

  a_psn_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.poisoned_packet && st.mask[12] && !flags_out[12]
    |=> !flags_out[12] && !report_out.bits[12])
    else $error("masked poisoned packet seen");

  a_dll_masked: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in.link_protocol && st.mask[4] && !flags_out[4]
    |=> !flags_out[4] && !report_out.bits[4])
    else $error("masked link protocol error seen");

  a_ack_follows: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd || cfg_req_in.wr
    |=> cfg_rsp_out.ack)
    else $error("access not acknowledged");

  a_ack_alone: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    !(cfg_req_in.rd || cfg_req_in.wr)
    |=> !cfg_rsp_out.ack)
    else $error("acknowledge without access");

  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd && cfg_req_in.addr == 12'h10C
    |=> cfg_rsp_out.rdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_flags_readback: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.rd && cfg_req_in.addr == 12'h104
    |=> cfg_rsp_out.rdata == $past(flags_out))
    else $error("flags read back wrong");

  a_mask_write: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.wr && cfg_req_in.addr == 12'h108 && cfg_req_in.be == 4'hF
    |=> st.mask == ($past(cfg_req_in.wdata) & 32'h001FF010))
    else $error("mask write not taken");

  a_w1c_clears: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    cfg_req_in.wr && cfg_req_in.addr == 12'h104 && cfg_req_in.be[2] && cfg_req_in.wdata[20]
    && !events_in.unsupported_request |=> !flags_out[20])
    else $error("write one did not clear");

  a_report_quiet: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    events_in == '0
    |=> !report_out.valid)
    else $error("report without event");

  a_valid_matches: assert property (@(posedge clk_in) disable iff (fundamental_reset)
    report_out.valid == (report_out.bits != 32'h00000000))
    else $error("report valid and bits disagree");

endmodule

// ---- test/aerunc_err_src.sv ----
// Error source model standing in for the link and transaction layers
`timescale 1ns/1ns

module aerunc_err_src (
  // Clock
  input  wire logic                  clk_in,
  // Events toward the register block
  output aerunc_pkg::aerunc_events_t ev_out
);
  import aerunc_pkg::*;
  initial ev_out = '0;
  // One-cycle event pulse, then idle
  task automatic pulse(input aerunc_events_t e);
    @(posedge clk_in);
    ev_out <= e;
    @(posedge clk_in);
    ev_out <= '0;
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the error status and mask registers
`timescale 1ns/1ns

module tb;
  import aerunc_pkg::*;
  // ****
  // Bench signals
  // ****
  logic            clk_in;
  logic            srst_in;
  logic            lnk_n;
  logic            glb_n;
  aerunc_cfg_req_t req;
  aerunc_cfg_rsp_t rsp;
  aerunc_events_t  ev;
  aerunc_report_t  rep;
  logic [31:0]     flags;
  logic [31:0]     r;
  int              err_total;
  int              n_compared;
  int              cyc;

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  aerunc_regs_top dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .link_reset_input_n_in(lnk_n), .global_reset_input_n_in(glb_n),
    .cfg_req_in(req), .cfg_rsp_out(rsp), .events_in(ev), .report_out(rep), .flags_out(flags)
  );
  aerunc_err_src src_u (.clk_in(clk_in), .ev_out(ev));

  function automatic int pos(input int i);
    return (i == 0) ? 4 : 11 + i;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_in);
    req <= '{rd: !w, wr: w, addr: a, be: 4'hF, wdata: d};
    @(posedge clk_in);
    req <= '0;
    q = 32'h0;
    for (k = 0; k < 4; k++) begin
      #1;
      if (rsp.ack === 1'b1) begin
        q = rsp.rdata;
        break;
      end
      @(posedge clk_in);
    end
    if (k == 4) begin
      err_total++;
      $display("MISMATCH t=%0t no ack", $time);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_header();
    cfg(0, 12'h100, 0, r);
    chk(r, 32'h00010001, "header");
    cfg(1, 12'h100, 32'hFFFFFFFF, r);
    cfg(0, 12'h100, 0, r);
    chk(r, 32'h00010001, "header wr");
    cfg(0, 12'h104, 0, r);
    chk(r, 32'h0, "flags rst");
    cfg(0, 12'h108, 0, r);
    chk(r, 32'h0, "mask rst");
    cfg(0, 12'h10C, 0, r);
    chk(r, 32'h0, "unmapped");
    $display("header test done err=%0d", err_total);
  endtask

  task automatic t_events();
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = 0; i < 10; i++) begin
      src_u.pulse(aerunc_events_t'(10'h1 << i));
      #1;
      acc = acc | (32'h1 << pos(i));
      chk({31'h0, rep.valid}, 32'h1, "rep valid");
      chk(rep.bits, 32'h1 << pos(i), "rep bits");
      chk(flags, acc, "flags set");
    end
    cfg(1, 12'h104, 32'h0, r);
    cfg(0, 12'h104, 0, r);
    chk(r, 32'h001FF010, "zero wr");
    cfg(1, 12'h104, 32'h00100000, r);
    cfg(0, 12'h104, 0, r);
    chk(r, 32'h000FF010, "w1c one");
    cfg(1, 12'h104, 32'hFFFFFFFF, r);
    chk(flags, 32'h0, "w1c all");
    $display("event test done err=%0d", err_total);
  endtask

  task automatic t_mask();
    cfg(1, 12'h108, 32'hFFFFFFFF, r);
    cfg(0, 12'h108, 0, r);
    chk(r, 32'h001FF010, "mask rw");
    src_u.pulse(aerunc_events_t'(10'h3FF));
    #1;
    chk({31'h0, rep.valid}, 32'h0, "masked rep");
    chk(flags, 32'h0, "masked flags");
    cfg(1, 12'h108, 32'h0, r);
    src_u.pulse(aerunc_events_t'(10'h3FF));
    #1;
    chk(flags, 32'h001FF010, "unmasked");
    fork
      cfg(1, 12'h104, 32'hFFFFFFFF, r);
      src_u.pulse(aerunc_events_t'(10'h100));
    join
    chk(flags, 32'h00080000, "set wins");
    $display("mask test done err=%0d", err_total);
  endtask

  task automatic t_fundamental_reset(input logic glb);
    cfg(1, 12'h108, 32'h00001000, r);
    src_u.pulse(aerunc_events_t'(10'h3FF));
    @(posedge clk_in);
    if (glb) glb_n <= 1'b0;
    else lnk_n <= 1'b0;
    @(posedge clk_in);
    glb_n <= 1'b1;
    lnk_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk(flags, 32'h0, "fundamental_reset flags");
    cfg(0, 12'h108, 0, r);
    chk(r, 32'h0, "fundamental_reset mask");
    $display("reset test done err=%0d", err_total);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  initial begin
    req = '0;
    srst_in = 1'b1;
    lnk_n = 1'b1;
    glb_n = 1'b1;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    t_header();
    t_events();
    t_mask();
    t_fundamental_reset(1'b0);
    t_fundamental_reset(1'b1);
    results();
  end
endmodule
